// ===== src/cfgio_pkg.sv
package cfgio_pkg;

  localparam int NPORT = 7;
  localparam int PORT_A = 0;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;

  // Per-port feature masks, bit p is port p (A=0 .. G=6)
  localparam logic [6:0] HAS_MODE = 7'h70;
  localparam logic [6:0] HAS_OE_TERM = 7'h27;
  localparam logic [6:0] HAS_SLEW = 7'h24;
  localparam logic [6:0] HAS_LCELL = 7'h03;
  localparam logic [6:0] HAS_ADDR_IN = 7'h2f;

  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_NARROW = 8'h0f;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Byte offset from the block base: {port index, register code}
  localparam int PORT_LSB = 4;
  localparam logic [3:0] REG_IN = 4'h0;
  localparam logic [3:0] REG_OUT = 4'h1;
  localparam logic [3:0] REG_DIR = 4'h2;
  localparam logic [3:0] REG_DRV = 4'h3;
  localparam logic [3:0] REG_MODE = 4'h4;
  localparam logic [3:0] REG_LCELL = 4'h5;
  localparam logic [3:0] REG_LMASK = 4'h6;
  localparam logic [3:0] REG_ENOUT = 4'h7;
  localparam logic [3:0] MAPCFG_PORT = 4'h7;
  localparam logic [3:0] REG_MAPCFG = 4'h0;
  localparam int PERIPH_BIT = 7;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfgio_bus_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] fast;
  } cfgio_pad_t;

  function automatic logic [7:0] width_mask(input logic [3:0] p);
    width_mask = (p == 4'(PORT_D)) ? MASK_NARROW : MASK_FULL;
  endfunction

endpackage

// ===== src/cfgio_port_bank.sv
`timescale 1ns/1ps
module cfgio_port_bank #(
  parameter logic [15:0] RESET_PATTERN = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // MCU register bus
  input cfgio_pkg::cfgio_bus_t bus,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  // MCU address and strobe
  input wire logic address_strobe_in,
  input wire logic [15:0] mcu_addr,
  // Port pins
  input wire logic [6:0][7:0] pin_in,
  output cfgio_pkg::cfgio_pad_t [6:0] pad_r,
  // General logic array
  input wire logic [6:0][7:0] logic_oe_term,
  input wire logic [6:0][7:0] logic_out,
  input wire logic [1:0] lc_load,
  input wire logic [1:0][7:0] lc_d,
  input wire logic [6:0][7:0] memory_decode_logic_uses,
  output logic [1:0][7:0] output_logic_cell_r,
  output logic [6:0][7:0] input_logic_cell_r,
  // Peripheral selects
  input wire logic periph_select_first,
  input wire logic periph_select_second,
  // Data port and MCU reset mode
  input wire logic data_port_mode,
  input wire logic reset_mode_en,
  input wire logic mcu_reset_active,
  input wire logic bus_cycle_active,
  input wire logic core_rd_drive,
  input wire logic [15:0] core_rdata,
  output logic [15:0] data_port_in_r
);

  logic [6:0][7:0] dout_r;
  logic [6:0][7:0] dir_r;
  logic [6:0][7:0] drv_r;
  logic [6:0][7:0] mode_r;
  logic [1:0][7:0] lmask_r;
  logic [7:0] mapcfg_r;
  logic [15:0] addr_lat_r;
  cfgio_pkg::cfgio_pad_t [6:0] pad_nxt;
  logic [7:0] rdata_nxt;
  logic periph_on;
  logic periph_sel;
  logic rst_drive;
  logic [3:0] rport;
  logic [3:0] rcode;

  assign rport = bus.addr[7:4];
  assign rcode = bus.addr[3:0];

  function automatic logic wr_hit(input logic [3:0] p,
                                  input logic [3:0] code);
    wr_hit = bus.sel && bus.wr && bus.addr == {p, code};
  endfunction

  assign periph_on = mapcfg_r[cfgio_pkg::PERIPH_BIT];
  assign periph_sel = periph_select_first | periph_select_second;
  // Pattern only while reset holds and the bus is quiet
  assign rst_drive = reset_mode_en & mcu_reset_active
                     & ~bus_cycle_active;

  // Configuration and output data registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout_r <= '0;
      dir_r <= '0;
      drv_r <= '0;
      mode_r <= '0;
      lmask_r <= '0;
      mapcfg_r <= cfgio_pkg::CFG_RESET;
    end else begin
      for (int p = 0; p < cfgio_pkg::NPORT; p++) begin
        // Narrow port keeps its upper bits at zero
        if (wr_hit(4'(p), cfgio_pkg::REG_OUT)) begin
          dout_r[p] <= bus.wdata
                       & cfgio_pkg::width_mask(4'(p));
        end
        if (wr_hit(4'(p), cfgio_pkg::REG_DIR)) begin
          dir_r[p] <= bus.wdata
                      & cfgio_pkg::width_mask(4'(p));
        end
        if (wr_hit(4'(p), cfgio_pkg::REG_DRV)) begin
          drv_r[p] <= bus.wdata & cfgio_pkg::width_mask(4'(p));
        end
        if (wr_hit(4'(p), cfgio_pkg::REG_MODE)
            && cfgio_pkg::HAS_MODE[p]) begin
          mode_r[p] <= bus.wdata;
        end
      end
      for (int q = 0; q < 2; q++) begin
        if (wr_hit(4'(q), cfgio_pkg::REG_LMASK)) begin
          lmask_r[q] <= bus.wdata;
        end
      end
      if (wr_hit(cfgio_pkg::MAPCFG_PORT, cfgio_pkg::REG_MAPCFG)) begin
        mapcfg_r <= bus.wdata;
      end
    end
  end

  // Output logic cells: MCU write to bits clear in lmask_r wins over the logic array load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_logic_cell_r <= '0;
    end else begin
      for (int q = 0; q < 2; q++) begin
        for (int b = 0; b < 8; b++) begin
          if (wr_hit(4'(q), cfgio_pkg::REG_LCELL) && !lmask_r[q][b]) begin
            output_logic_cell_r[q][b] <= bus.wdata[b];
          end else if (lc_load[q]) begin
            output_logic_cell_r[q][b] <= lc_d[q][b];
          end
        end
      end
    end
  end

  // Address register, loaded on each clock edge while the strobe is high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_lat_r <= '0;
    end else if (address_strobe_in) begin
      addr_lat_r <= mcu_addr;
    end
  end

  // Input cells: address bits hold between strobes, others follow pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_logic_cell_r <= '0;
    end else begin
      for (int p = 0; p < cfgio_pkg::NPORT; p++) begin
        for (int b = 0; b < 8; b++) begin
          if (!(cfgio_pkg::HAS_ADDR_IN[p]
                && memory_decode_logic_uses[p][b])) begin
            input_logic_cell_r[p][b] <= pin_in[p][b];
          end else if (address_strobe_in) begin
            input_logic_cell_r[p][b] <= pin_in[p][b];
          end
        end
      end
    end
  end

  // Pad logic, one block per port
  for (genvar p = 0; p < cfgio_pkg::NPORT; p++) begin : g_port
    logic [7:0] wm;
    logic [7:0] oe_t;
    logic [7:0] mode;
    logic [7:0] od;
    logic [7:0] addr_src;
    logic [7:0] lout;
    logic [7:0] val;
    logic [7:0] drive_en;
    logic [7:0] addr_en;

    assign wm = cfgio_pkg::width_mask(4'(p));
    assign oe_t = cfgio_pkg::HAS_OE_TERM[p] ? logic_oe_term[p] : '0;
    assign mode = cfgio_pkg::HAS_MODE[p] ? mode_r[p] : '0;
    // Slew ports have no open-drain option
    assign od = cfgio_pkg::HAS_SLEW[p] ? '0 : drv_r[p];
    assign addr_src = (p == cfgio_pkg::PORT_G) ? addr_lat_r[15:8]
                                                : addr_lat_r[7:0];
    if (p < 2) begin : g_lc
      assign lout = output_logic_cell_r[p];
    end else begin : g_nolc
      assign lout = logic_out[p];
    end
    assign addr_en = mode & (oe_t | dir_r[p]);
    assign drive_en = (dir_r[p] | oe_t) & wm;

    // Bitwise so each pin follows only its own bits
    always_comb begin
      for (int b = 0; b < 8; b++) begin
        if (addr_en[b]) begin
          val[b] = addr_src[b];
        end else if (oe_t[b] && !dir_r[p][b]) begin
          val[b] = lout[b];
        end else begin
          val[b] = dout_r[p][b];
        end
      end
    end

    always_comb begin
      pad_nxt[p].out = val & ~od;
      // Open drain releases the pin for a one
      pad_nxt[p].oe = drive_en & ~(od & val);
      pad_nxt[p].fast = cfgio_pkg::HAS_SLEW[p]
                        ? (drv_r[p] & wm) : '0;
      if (p == cfgio_pkg::PORT_F || p == cfgio_pkg::PORT_G) begin
        if (rst_drive) begin
          pad_nxt[p].out = (p == cfgio_pkg::PORT_G)
                           ? RESET_PATTERN[15:8]
                           : RESET_PATTERN[7:0];
          pad_nxt[p].oe = cfgio_pkg::MASK_FULL;
        end else if (data_port_mode) begin
          // General I/O is off; the port is the data bus
          pad_nxt[p].out = (p == cfgio_pkg::PORT_G)
                           ? core_rdata[15:8] : core_rdata[7:0];
          pad_nxt[p].oe = core_rd_drive ? cfgio_pkg::MASK_FULL
                                        : '0;
        end else if (p == cfgio_pkg::PORT_F && periph_on) begin
          pad_nxt[p].out = bus.wdata;
          pad_nxt[p].oe = (periph_sel && bus.wr)
                          ? cfgio_pkg::MASK_FULL : '0;
        end
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pad_r[p] <= '0;
      end else begin
        pad_r[p] <= pad_nxt[p];
      end
    end
  end

  // Data bus levels seen on F and G in data port mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_port_in_r <= '0;
    end else if (data_port_mode) begin
      data_port_in_r <= {pin_in[cfgio_pkg::PORT_G],
                         pin_in[cfgio_pkg::PORT_F]};
    end
  end

  // Read path; unmapped offsets read zero
  always_comb begin
    rdata_nxt = '0;
    if (periph_on && periph_sel && !data_port_mode) begin
      rdata_nxt = pin_in[cfgio_pkg::PORT_F];
    end else if (rport < 4'(cfgio_pkg::NPORT)) begin
      case (rcode)
        cfgio_pkg::REG_IN: begin
          rdata_nxt = pin_in[rport[2:0]]
                      & cfgio_pkg::width_mask(rport);
        end
        cfgio_pkg::REG_OUT: begin
          rdata_nxt = dout_r[rport[2:0]];
        end
        cfgio_pkg::REG_DIR: begin
          rdata_nxt = dir_r[rport[2:0]];
        end
        cfgio_pkg::REG_DRV: begin
          rdata_nxt = drv_r[rport[2:0]];
        end
        cfgio_pkg::REG_MODE: begin
          rdata_nxt = mode_r[rport[2:0]];
        end
        cfgio_pkg::REG_LCELL: begin
          if (rport < 4'h2) begin
            rdata_nxt = output_logic_cell_r[rport[0]];
          end
        end
        cfgio_pkg::REG_LMASK: begin
          if (rport < 4'h2) begin
            rdata_nxt = lmask_r[rport[0]];
          end
        end
        cfgio_pkg::REG_ENOUT: begin
          if (cfgio_pkg::HAS_OE_TERM[rport[2:0]]) begin
            rdata_nxt = pad_r[rport[2:0]].oe;
          end
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end else if (rport == cfgio_pkg::MAPCFG_PORT
                 && rcode == cfgio_pkg::REG_MAPCFG) begin
      rdata_nxt = mapcfg_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= bus.rd && (bus.sel || (periph_on && periph_sel));
      if (bus.rd && (bus.sel || (periph_on && periph_sel))) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

endmodule

// ===== tb/cfgio_port_bank_assertions.sv
`timescale 1ns/1ps
module cfgio_port_bank_chk #(
  parameter logic [15:0] RESET_PATTERN = 16'h0000
) (
  // Clock, reset and register bus
  input wire logic clk,
  input wire logic resetn,
  input cfgio_pkg::cfgio_bus_t bus,
  input wire logic [7:0] rdata_r,
  input wire logic rvalid_r,
  // Pins and logic array
  input wire logic [6:0][7:0] pin_in,
  input cfgio_pkg::cfgio_pad_t [6:0] pad_r,
  input wire logic [6:0][7:0] logic_oe_term,
  input wire logic [6:0][7:0] memory_decode_logic_uses,
  input wire logic [6:0][7:0] input_logic_cell_r,
  input wire logic address_strobe_in,
  // Modes
  input wire logic periph_select_first,
  input wire logic periph_select_second,
  input wire logic data_port_mode,
  input wire logic reset_mode_en,
  input wire logic mcu_reset_active,
  input wire logic bus_cycle_active,
  input wire logic core_rd_drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rmode, psel, rd_ok;
  assign rmode = reset_mode_en & mcu_reset_active & !bus_cycle_active;
  assign psel = periph_select_first | periph_select_second;
  // Peripheral reads reuse rdata_r, so register-read checks exclude them
  assign rd_ok = bus.sel & bus.rd & !psel;
  property p_rd_valid;
    bus.sel && bus.rd |=> rvalid_r;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read gave no valid");
  property p_wr_quiet;
    bus.sel && bus.wr && !bus.rd && !psel |=> !rvalid_r;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("write gave a valid");
  property p_rd_pins;
    rd_ok && bus.addr == 8'h20 |=> rdata_r == $past(pin_in[2]);
  endproperty
  a_rd_pins: assert property (p_rd_pins)
    else $error("input read not live pins");
  property p_unmapped;
    rd_ok && bus.addr[3] |=> rdata_r == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_oe_term;
    $past(resetn) |-> (pad_r[2].oe & $past(logic_oe_term[2]))
      == $past(logic_oe_term[2]);
  endproperty
  a_oe_term: assert property (p_oe_term)
    else $error("enable term did not drive");
  property p_rst_mode;
    rmode |=> {pad_r[6].oe, pad_r[5].oe} == 16'hffff
      && {pad_r[6].out, pad_r[5].out} == RESET_PATTERN;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("reset pattern not driven");
  property p_data_port;
    data_port_mode && !rmode |=> {pad_r[6].oe, pad_r[5].oe}
      == {16{$past(core_rd_drive)}};
  endproperty
  a_data_port: assert property (p_data_port)
    else $error("data port enable wrong");
  property p_icell;
    $past(resetn) |-> ((input_logic_cell_r[2] ^ $past(pin_in[2]))
      & ~$past(memory_decode_logic_uses[2])) == 8'h00;
  endproperty
  a_icell: assert property (p_icell)
    else $error("input cell not following pin");
  // Address bits must hold their latched value between strobes
  property p_icell_hold;
    !address_strobe_in |=> ((input_logic_cell_r[2]
      ^ $past(input_logic_cell_r[2])) & $past(memory_decode_logic_uses[2]))
      == 8'h00;
  endproperty
  a_icell_hold: assert property (p_icell_hold)
    else $error("address input cell moved without strobe");
  c_rmode: cover property (rmode);
  c_lcell: cover property (bus.sel && bus.wr && bus.addr == 8'h05);
  c_periph: cover property (psel && bus.wr);
endmodule
bind cfgio_port_bank cfgio_port_bank_chk #(.RESET_PATTERN(RESET_PATTERN))
  u_chk (.clk, .resetn, .bus, .rdata_r, .rvalid_r, .pin_in, .pad_r,
  .logic_oe_term, .memory_decode_logic_uses, .input_logic_cell_r,
  .address_strobe_in,
  .periph_select_first, .periph_select_second, .data_port_mode,
  .reset_mode_en, .mcu_reset_active, .bus_cycle_active, .core_rd_drive);

// ===== tb/cfgio_pin_model.sv
`timescale 1ns/1ps
module cfgio_pin_model (
  // Device pads and far-side drivers
  input cfgio_pkg::cfgio_pad_t [6:0] pad_r,
  input wire logic [6:0][7:0] ext,
  input wire logic [6:0][7:0] ext_en,
  input wire logic mcu_reset_active,
  // Resolved pin levels and captured straps
  output logic [6:0][7:0] pin_in,
  output logic [15:0] strap
);
  // Released pins sit on pull-ups, which also lift open-drain highs
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      pin_in[p] = (pad_r[p].oe & pad_r[p].out)
        | (~pad_r[p].oe & ~(ext_en[p] & ~ext[p]));
    end
  end
  // The MCU latches data lines 15..0 as its reset ends
  always @(negedge mcu_reset_active) begin
    strap <= {pin_in[6], pin_in[5]};
  end
endmodule

// ===== tb/cfgio_port_bank_test.sv
`timescale 1ns/1ps
module cfgio_port_bank_test;
  logic clk = 1'b0, resetn = 1'b0, rvalid_r, address_strobe_in = 1'b0;
  logic periph_select_first = 1'b0, periph_select_second = 1'b0;
  logic data_port_mode = 1'b0, core_rd_drive = 1'b0, bus_cycle_active = 1'b0;
  logic reset_mode_en = 1'b1, mcu_reset_active = 1'b1;
  logic [1:0] lc_load = '0;
  logic [1:0][7:0] lc_d = '0;
  logic [7:0] rdata_r, v, e, m;
  logic [15:0] mcu_addr = '0, core_rdata = '0, data_port_in_r, strap;
  logic [31:0] seed = 32'h0c9517bf;
  logic [6:0][7:0] pin_in, logic_oe_term = '0, logic_out = '0;
  logic [6:0][7:0] uses = '0, ext = '0, ext_en = '0;
  cfgio_pkg::cfgio_bus_t bus = '0;
  cfgio_pkg::cfgio_pad_t [6:0] pad_r;
  int failures = 0, comparisons = 0;
  logic [7:0] q[$];
  cfgio_port_bank #(.RESET_PATTERN(16'ha55a)) uut (.clk, .resetn, .bus,
    .rdata_r, .rvalid_r, .address_strobe_in, .mcu_addr, .pin_in, .pad_r,
    .logic_oe_term, .logic_out, .lc_load, .lc_d,
    .memory_decode_logic_uses(uses), .output_logic_cell_r(),
    .input_logic_cell_r(), .periph_select_first, .periph_select_second,
    .data_port_mode, .reset_mode_en, .mcu_reset_active, .bus_cycle_active,
    .core_rd_drive, .core_rdata, .data_port_in_r);
  cfgio_pin_model far (.pad_r, .ext, .ext_en, .mcu_reset_active, .pin_in,
    .strap);
  always #4 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] g, x);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    bus = '{1'b1, !w, w, a, d};
    if (!w) q.push_back(d);
    @(negedge clk);
    bus = '0;
  endtask
  // A select with write drives the port; a select with read samples it
  task automatic pxf(input logic w, input logic [7:0] d);
    @(negedge clk);
    {periph_select_second, periph_select_first} = w ? 2'b01 : 2'b10;
    bus = '{1'b0, !w, w, 8'h00, d};
    @(negedge clk);
    {periph_select_second, periph_select_first} = 2'b00;
    bus = '0;
  endtask
  always @(negedge clk) if (rvalid_r === 1'b1)
    chk(16'(rdata_r), 16'(q.pop_front()));
  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    for (int p = 0; p < 7; p++) begin
      acc(0, 8'(p * 16 + 2), 8'h00);
      acc(0, 8'(p * 16 + 3), 8'h00);
      if (p > 3) acc(0, 8'(p * 16 + 4), 8'h00);
    end
    mcu_reset_active = 1'b0;
    repeat (2) @(negedge clk);
    chk(strap, 16'ha55a);
    chk(16'(pad_r[5].oe), 16'h0000);
    $display("done: reset");
    for (int p = 0; p < 7; p++) begin
      e = 8'(rnd());
      v = 8'(rnd());
      m = (p == 3) ? 8'h0f : 8'hff;
      ext[p] = 8'(rnd());
      ext_en[p] = 8'hff;
      acc(1, 8'(p * 16 + 1), e);
      acc(1, 8'(p * 16 + 2), v);
      repeat (2) @(negedge clk);
      acc(0, 8'(p * 16), ((v & e) | (~v & ext[p])) & m);
      acc(0, 8'(p * 16 + 1), e & m);
      acc(0, 8'(p * 16 + 2), v & m);
    end
    $display("done: pins");
    acc(1, 8'h23, 8'hff);
    acc(1, 8'h01, 8'h5a);
    acc(1, 8'h02, 8'hff);
    acc(1, 8'h03, 8'hff);
    acc(1, 8'h04, 8'hff);
    acc(0, 8'h04, 8'h00);
    acc(0, 8'h08, 8'h00);
    acc(0, 8'h07, 8'ha5);
    acc(0, 8'h37, 8'h00);
    chk({pad_r[2].fast, pad_r[0].fast}, 16'hff00);
    chk(16'(pad_r[0].oe), 16'h00a5);
    $display("done: drive");
    acc(1, 8'h05, 8'h3c);
    acc(1, 8'h06, 8'hf0);
    acc(1, 8'h05, 8'hc3);
    acc(0, 8'h05, 8'h33);
    acc(0, 8'h06, 8'hf0);
    acc(0, 8'h16, 8'h00);
    $display("done: cells");
    acc(1, 8'h52, 8'h00);
    acc(1, 8'h70, 8'h80);
    pxf(1, 8'h96);
    chk({pad_r[5].oe, pad_r[5].out}, 16'hff96);
    @(negedge clk);
    chk(16'(pad_r[5].oe), 16'h0000);
    q.push_back(ext[5]);
    pxf(0, 8'h00);
    acc(1, 8'h70, 8'h00);
    pxf(1, 8'h69);
    chk(16'(pad_r[5].oe), 16'h0000);
    $display("done: peripheral");
    acc(1, 8'h42, 8'hff);
    acc(1, 8'h44, 8'hff);
    acc(0, 8'h44, 8'hff);
    @(negedge clk);
    mcu_addr = 16'(rnd());
    address_strobe_in = 1'b1;
    @(negedge clk);
    address_strobe_in = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(pad_r[4].out), 16'(mcu_addr[7:0]));
    $display("done: address out");
    data_port_mode = 1'b1;
    core_rd_drive = 1'b1;
    core_rdata = 16'(rnd());
    repeat (3) @(negedge clk);
    chk({pad_r[6].out, pad_r[5].out}, core_rdata);
    chk(data_port_in_r, core_rdata);
    $display("done: data port");
    repeat (300) begin
      @(negedge clk);
      logic_oe_term = 56'({rnd(), rnd()});
      logic_out = 56'({rnd(), rnd()});
      uses = 56'({rnd(), rnd()});
      ext = 56'({rnd(), rnd()});
      {mcu_addr, core_rdata} = rnd();
      {lc_d, lc_load, address_strobe_in, data_port_mode, core_rd_drive,
        reset_mode_en, mcu_reset_active, bus_cycle_active} = 24'(rnd());
    end
    $display("done: random");
    conclude();
  end
endmodule
